// *** verilog/cio_top.v ***
/*
 * Camera discrete I/O and status indicators: two conditioned inputs used
 * as trigger or exposure control, two function-selectable outputs with a
 * minimum pulse width, a priority-encoded status LED and two network LEDs.
 * Assumes a single 40 MHz clock, all control bits static or from logic on
 * that clock; input pins are asynchronous.
 */
// Function
// - each input acts as acquisition trigger or exposure-period control
// - per-input setting chooses which polarity is active
// - per-input debounce programmable in whole microseconds, 1 to 255
// - each output selects a function, including strobe and event notification
// - every generated output pulse lasts at least 100 microseconds
// - status LED shows only the highest-priority active condition
// - red: steady not initialized, slow init failure, fast over-temperature
// - blue: slow awaiting address, fast link lost, steady addressed idle
// - green: steady connected, slow triggered, fast free-running acquisition
// - connection LED green at 100 Mbps, orange at 1000 Mbps
// - activity LED dark without traffic, blinking yellow with traffic
`timescale 1ns/1ps
`default_nettype none
`include "cio_consts.vh"

module cio_top (
    input wire clk_i,
    input wire nrst_i,
    input wire in1_pin_i,
    input wire in2_pin_i,
    input wire in1_invert_i,
    input wire in2_invert_i,
    input wire in1_use_i,
    input wire in2_use_i,
    input wire [`CIO_DEB_W-1:0] in1_deb_us_i,
    input wire [`CIO_DEB_W-1:0] in2_deb_us_i,
    input wire [`CIO_OF_W-1:0] out1_func_i,
    input wire [`CIO_OF_W-1:0] out2_func_i,
    input wire out1_level_i,
    input wire out2_level_i,
    input wire strobe_i,
    input wire event_i,
    input wire not_init_i,
    input wire init_fail_i,
    input wire over_temp_i,
    input wire wait_ip_i,
    input wire link_down_i,
    input wire ip_ok_i,
    input wire app_conn_i,
    input wire acq_trig_i,
    input wire acq_free_i,
    input wire link_up_i,
    input wire link_1000_i,
    input wire net_act_i,
    output reg trig_o,
    output reg expose_o,
    output reg out1_o,
    output reg out2_o,
    output reg [2:0] status_rgb_o,
    output reg [1:0] link_led_o,
    output reg act_led_o
);

// ****************************************
// time base
// ****************************************
reg [`CIO_US_CNT_W-1:0] us_cnt;
reg us_tick;
reg [`CIO_BLINK_W-1:0] blink_cnt;

always @(posedge clk_i) begin
    if (!nrst_i) begin
        us_cnt <= 6'h00;
        us_tick <= 1'b0;
        blink_cnt <= 25'h0000000;
    end else begin
        us_tick <= (us_cnt == `CIO_US_LAST);
        if (us_cnt == `CIO_US_LAST) begin
            us_cnt <= 6'h00;
        end else begin
            us_cnt <= us_cnt + 6'h01;
        end
        blink_cnt <= blink_cnt + 25'h0000001;
    end
end

// slow period 2^25 cycles (~0.84 s), fast 2^23 (~0.21 s)
wire slow_on = blink_cnt[`CIO_SLOW_BIT];
wire fast_on = blink_cnt[`CIO_FAST_BIT];

// ****************************************
// external inputs
// ****************************************
wire in1_lvl;
wire in1_rise;
wire in2_lvl;
wire in2_rise;

cio_input_cond u_in1 (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .pin_i(in1_pin_i),
    .invert_i(in1_invert_i),
    .deb_us_i(in1_deb_us_i),
    .us_tick_i(us_tick),
    .level_o(in1_lvl),
    .rise_o(in1_rise),
    .fall_o()
);

cio_input_cond u_in2 (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .pin_i(in2_pin_i),
    .invert_i(in2_invert_i),
    .deb_us_i(in2_deb_us_i),
    .us_tick_i(us_tick),
    .level_o(in2_lvl),
    .rise_o(in2_rise),
    .fall_o()
);

// trigger is one pulse per active edge; exposure follows the active level
always @(posedge clk_i) begin
    if (!nrst_i) begin
        trig_o <= 1'b0;
        expose_o <= 1'b0;
    end else begin
        trig_o <= (in1_use_i == `CIO_IN_TRIGGER && in1_rise) ||
                  (in2_use_i == `CIO_IN_TRIGGER && in2_rise);
        expose_o <= (in1_use_i == `CIO_IN_EXPOSURE && in1_lvl) ||
                    (in2_use_i == `CIO_IN_EXPOSURE && in2_lvl);
    end
end

// ****************************************
// external outputs
// ****************************************
reg [`CIO_PULSE_CNT_W-1:0] hold1;
reg [`CIO_PULSE_CNT_W-1:0] hold2;
reg [`CIO_US_CNT_W-1:0] sub1;
reg [`CIO_US_CNT_W-1:0] sub2;
reg req1;
reg req2;

always @* begin
    case (out1_func_i)
        `CIO_OF_STROBE: req1 = strobe_i;
        `CIO_OF_EVENT: req1 = event_i;
        `CIO_OF_LEVEL: req1 = out1_level_i;
        default: req1 = 1'b0;
    endcase
    case (out2_func_i)
        `CIO_OF_STROBE: req2 = strobe_i;
        `CIO_OF_EVENT: req2 = event_i;
        `CIO_OF_LEVEL: req2 = out2_level_i;
        default: req2 = 1'b0;
    endcase
end

// a request starts a pulse; it stays high while the request lasts and for
// at least 100 us counted in whole microseconds of 40 clocks each
always @(posedge clk_i) begin
    if (!nrst_i) begin
        out1_o <= 1'b0;
        out2_o <= 1'b0;
        hold1 <= 8'h00;
        hold2 <= 8'h00;
        sub1 <= 6'h00;
        sub2 <= 6'h00;
    end else begin
        if (req1) begin
            out1_o <= 1'b1;
            hold1 <= `CIO_PULSE_LAST;
            sub1 <= 6'h00;
        end else if (hold1 != 8'h00 || sub1 != `CIO_US_LAST) begin
            if (sub1 == `CIO_US_LAST) begin
                sub1 <= 6'h00;
                hold1 <= hold1 - 8'h01;
            end else begin
                sub1 <= sub1 + 6'h01;
            end
        end else begin
            out1_o <= 1'b0;
        end
        if (req2) begin
            out2_o <= 1'b1;
            hold2 <= `CIO_PULSE_LAST;
            sub2 <= 6'h00;
        end else if (hold2 != 8'h00 || sub2 != `CIO_US_LAST) begin
            if (sub2 == `CIO_US_LAST) begin
                sub2 <= 6'h00;
                hold2 <= hold2 - 8'h01;
            end else begin
                sub2 <= sub2 + 6'h01;
            end
        end else begin
            out2_o <= 1'b0;
        end
    end
end

// ****************************************
// status and network leds
// ****************************************
reg [2:0] next_rgb;

// priority falls from top to bottom; a lower condition is hidden entirely
always @* begin
    if (over_temp_i) begin
        next_rgb = fast_on ? `CIO_RGB_RED : `CIO_RGB_OFF;
    end else if (init_fail_i) begin
        next_rgb = slow_on ? `CIO_RGB_RED : `CIO_RGB_OFF;
    end else if (not_init_i) begin
        next_rgb = `CIO_RGB_RED;
    end else if (link_down_i) begin
        next_rgb = fast_on ? `CIO_RGB_BLUE : `CIO_RGB_OFF;
    end else if (wait_ip_i) begin
        next_rgb = slow_on ? `CIO_RGB_BLUE : `CIO_RGB_OFF;
    end else if (acq_free_i) begin
        next_rgb = fast_on ? `CIO_RGB_GREEN : `CIO_RGB_OFF;
    end else if (acq_trig_i) begin
        next_rgb = slow_on ? `CIO_RGB_GREEN : `CIO_RGB_OFF;
    end else if (app_conn_i) begin
        next_rgb = `CIO_RGB_GREEN;
    end else if (ip_ok_i) begin
        next_rgb = `CIO_RGB_BLUE;
    end else begin
        next_rgb = `CIO_RGB_RED;
    end
end

always @(posedge clk_i) begin
    if (!nrst_i) begin
        status_rgb_o <= `CIO_RGB_RED;
        link_led_o <= `CIO_LNK_OFF;
        act_led_o <= 1'b0;
    end else begin
        status_rgb_o <= next_rgb;
        if (!link_up_i) begin
            link_led_o <= `CIO_LNK_OFF;
        end else if (link_1000_i) begin
            link_led_o <= `CIO_LNK_ORANGE;
        end else begin
            link_led_o <= `CIO_LNK_GREEN;
        end
        act_led_o <= net_act_i & blink_cnt[`CIO_ACT_BIT];
    end
end

endmodule
`default_nettype wire

// *** verilog/cio_consts.vh ***
/*
 * Constants for the camera discrete I/O and status indicator block.
 * Assumes a 40 MHz system clock; included by bare name.
 */
`ifndef CIO_CONSTS_VH
`define CIO_CONSTS_VH

// ****************************************
// timing
// ****************************************
`define CIO_CLK_MHZ 40
`define CIO_US_CYCLES (`CIO_CLK_MHZ)
`define CIO_US_CNT_W 6
`define CIO_US_LAST 6'h27
`define CIO_PULSE_MIN_US 100
`define CIO_PULSE_CNT_W 8
`define CIO_PULSE_LAST 8'h63
`define CIO_DEB_W 8
`define CIO_DEB_MIN 8'h01
`define CIO_SLOW_MS 500
`define CIO_FAST_MS 125
`define CIO_SLOW_CYC (`CIO_SLOW_MS * 1000 * `CIO_CLK_MHZ)
`define CIO_FAST_CYC (`CIO_FAST_MS * 1000 * `CIO_CLK_MHZ)
`define CIO_BLINK_W 25
`define CIO_SLOW_BIT 24
`define CIO_FAST_BIT 22
`define CIO_ACT_BIT 21

// ****************************************
// input use and output function codes
// ****************************************
`define CIO_IN_TRIGGER 1'b0
`define CIO_IN_EXPOSURE 1'b1
`define CIO_OF_W 2
`define CIO_OF_OFF 2'h0
`define CIO_OF_STROBE 2'h1
`define CIO_OF_EVENT 2'h2
`define CIO_OF_LEVEL 2'h3

// ****************************************
// led codes
// ****************************************
`define CIO_RGB_OFF 3'h0
`define CIO_RGB_RED 3'h4
`define CIO_RGB_GREEN 3'h2
`define CIO_RGB_BLUE 3'h1
`define CIO_LNK_OFF 2'h0
`define CIO_LNK_GREEN 2'h1
`define CIO_LNK_ORANGE 2'h2

`endif

// *** verilog/cio_input_cond.v ***
/*
 * One conditioned external input: synchroniser, polarity, debounce.
 * Assumes us_tick_i is a one-cycle pulse once per microsecond.
 */
`timescale 1ns/1ps
`default_nettype none
`include "cio_consts.vh"

module cio_input_cond (
    input wire clk_i,
    input wire nrst_i,
    input wire pin_i,
    input wire invert_i,
    input wire [`CIO_DEB_W-1:0] deb_us_i,
    input wire us_tick_i,
    output reg level_o,
    output reg rise_o,
    output reg fall_o
);

reg sync_a;
reg sync_b;
reg [`CIO_DEB_W-1:0] stable_cnt;
wire [`CIO_DEB_W-1:0] deb_eff;
wire active;

// a zero setting would disable filtering; clamp to the shortest interval
assign deb_eff = (deb_us_i < `CIO_DEB_MIN) ? `CIO_DEB_MIN : deb_us_i;
assign active = sync_b ^ invert_i;

always @(posedge clk_i) begin
    if (!nrst_i) begin
        sync_a <= 1'b0;
        sync_b <= 1'b0;
        stable_cnt <= 8'h00;
        level_o <= 1'b0;
        rise_o <= 1'b0;
        fall_o <= 1'b0;
    end else begin
        sync_a <= pin_i;
        sync_b <= sync_a;
        rise_o <= 1'b0;
        fall_o <= 1'b0;
        if (active == level_o) begin
            stable_cnt <= 8'h00;
        end else if (us_tick_i) begin
            // the first tick may land just after the change; one extra tick
            // keeps the accepted interval at or above the programmed one
            if (stable_cnt >= deb_eff) begin
                level_o <= active;
                rise_o <= active;
                fall_o <= ~active;
                stable_cnt <= 8'h00;
            end else begin
                stable_cnt <= stable_cnt + 8'h01;
            end
        end
    end
end

endmodule
`default_nettype wire

// *** verif/cio_ext_src.sv ***
/*
 * Behavioural source for one isolated camera input pin, bounce included.
 * Assumes it is the only driver of its pin and shares the bench clock.
 */
`timescale 1ns/1ps
`default_nettype none
module cio_ext_src (
    input wire logic clk_i,
    output logic pin_o
);
    initial pin_o = 1'b0;
    // ****
    // pin driver
    // ****
    // short holds stand for contact bounce; the pin is async, so no edge is special
    task automatic drive(input logic lvl, input int n);
        @(negedge clk_i);
        pin_o = lvl;
        repeat (n) @(negedge clk_i);
    endtask
endmodule
`default_nettype wire

// *** verif/cio_top_monitor.sv ***
/*
 * Checker beside cio_top: trigger pulse, debounce hold, output functions,
 * pulse width, status priority and network leds.
 * Assumes the 40 MHz clock and cio_consts.vh on the include path.
 */
`timescale 1ns/1ps
`default_nettype none
`include "cio_consts.vh"
module cio_top_monitor (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic in1_pin_i,
    input wire logic in1_use_i,
    input wire logic in2_use_i,
    input wire logic [`CIO_DEB_W-1:0] in1_deb_us_i,
    input wire logic [`CIO_OF_W-1:0] out1_func_i,
    input wire logic [`CIO_OF_W-1:0] out2_func_i,
    input wire logic strobe_i,
    input wire logic event_i,
    input wire logic over_temp_i,
    input wire logic init_fail_i,
    input wire logic not_init_i,
    input wire logic link_down_i,
    input wire logic wait_ip_i,
    input wire logic acq_free_i,
    input wire logic acq_trig_i,
    input wire logic app_conn_i,
    input wire logic ip_ok_i,
    input wire logic link_up_i,
    input wire logic link_1000_i,
    input wire logic net_act_i,
    input wire logic trig_o,
    input wire logic out1_o,
    input wire logic out2_o,
    input wire logic [2:0] status_rgb_o,
    input wire logic [1:0] link_led_o,
    input wire logic act_led_o
);
    logic pin_q;
    logic [12:0] hi1;
    logic [15:0] stab1;
    logic [8:0] st;
    assign st = {over_temp_i, init_fail_i, not_init_i, link_down_i, wait_ip_i,
                 acq_free_i, acq_trig_i, app_conn_i, ip_ok_i};
    // ****
    // helper counters
    // ****
    always_ff @(posedge clk_i) begin
        pin_q <= in1_pin_i;
        // saturate so a long level-follow pulse cannot wrap the count
        hi1 <= out1_o ? ((hi1 == 13'h1FFF) ? hi1 : hi1 + 13'h1) : 13'h0;
        if (!nrst_i || in1_pin_i != pin_q)
            stab1 <= 16'h0;
        else if (stab1 != 16'hFFFF)
            stab1 <= stab1 + 16'h1;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    a_trig_pulse: assert property (trig_o |=> !trig_o)
        else $error("trigger pulse longer than one cycle");
    // pin pulses shorter than the interval must never reach the trigger
    // only input one may trigger here, so its pin alone decides the hold time
    a_deb_hold: assert property (trig_o && in1_use_i == `CIO_IN_TRIGGER &&
        in2_use_i == `CIO_IN_EXPOSURE |-> stab1 >= 40 * in1_deb_us_i)
        else $error("trigger before the debounce interval ran out");
    a_strobe_out: assert property (out1_func_i == `CIO_OF_STROBE && strobe_i |=> out1_o)
        else $error("strobe request not on output one");
    a_event_out: assert property (out2_func_i == `CIO_OF_EVENT && event_i |=> out2_o)
        else $error("event request not on output two");
    a_pulse_min: assert property ($fell(out1_o) |-> hi1 >= 4000)
        else $error("output pulse shorter than minimum");
    a_temp_first: assert property (over_temp_i |=> status_rgb_o[1:0] == 2'h0)
        else $error("over temperature not shown in red");
    a_green_conn: assert property (st[8:2] == 7'h0 && app_conn_i |=>
        status_rgb_o == `CIO_RGB_GREEN)
        else $error("connected state not steady green");
    a_blue_ip: assert property (st[8:1] == 8'h0 && ip_ok_i |=> status_rgb_o == `CIO_RGB_BLUE)
        else $error("addressed state not steady blue");
    a_red_steady: assert property (st[8:7] == 2'h0 && (not_init_i || st == 9'h0) |=>
        status_rgb_o == `CIO_RGB_RED)
        else $error("uninitialised state not steady red");
    a_link_speed: assert property (link_up_i |=> link_led_o ==
        ($past(link_1000_i) ? `CIO_LNK_ORANGE : `CIO_LNK_GREEN))
        else $error("link led colour wrong");
    a_act_dark: assert property (!net_act_i |=> !act_led_o)
        else $error("activity led lit without traffic");
    cover property ($fell(out1_o));
    cover property (trig_o);
    cover property (st[8:2] == 7'h0 && app_conn_i);
endmodule
bind cio_top cio_top_monitor i_cio_top_monitor (
    .clk_i, .nrst_i, .in1_pin_i, .in1_use_i, .in2_use_i, .in1_deb_us_i, .out1_func_i,
    .out2_func_i,
    .strobe_i, .event_i, .over_temp_i, .init_fail_i, .not_init_i, .link_down_i, .wait_ip_i,
    .acq_free_i, .acq_trig_i, .app_conn_i, .ip_ok_i, .link_up_i, .link_1000_i, .net_act_i,
    .trig_o, .out1_o, .out2_o, .status_rgb_o, .link_led_o, .act_led_o
);
`default_nettype wire

// *** verif/testbench.sv ***
/*
 * Bench for cio_top: led priority, debounced inputs, output functions.
 * Assumes cio_ext_src drives both input pins; 40 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "cio_consts.vh"
module testbench;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] deb1 = 8'h02;
    logic [1:0] func1 = 2'h0;
    logic [1:0] func2 = 2'h0;
    logic [3:0] req = 4'h0;
    logic [8:0] st = 9'h000;
    logic [2:0] net = 3'h0;
    logic [31:0] seed = 32'hE421;
    logic [3:0] ntrig = 4'h0;
    logic [3:0] et = 4'h0;
    logic ex = 1'b0;
    logic [5:0] le;
    logic [12:0] q[$];
    int failures = 0;
    int total_checks = 0;
    int cyc = 0;
    int d;
    wire p1, p2, trig, expo, o1, o2, act;
    wire [2:0] rgb;
    wire [1:0] lnk;
    event ev;
    // flash phases start dark and the run ends long before the first lit one
    logic [2:0] rgb_t [10] = '{3'h0, 3'h0, 3'h4, 3'h0, 3'h0, 3'h0, 3'h0, 3'h2, 3'h1, 3'h4};
    always #12.5 clk = ~clk;
    cio_ext_src src1 (.clk_i(clk), .pin_o(p1));
    cio_ext_src src2 (.clk_i(clk), .pin_o(p2));
    cio_top i_cio_top (
        .clk_i(clk), .nrst_i(nrst), .in1_pin_i(p1), .in2_pin_i(p2),
        .in1_invert_i(1'b0), .in2_invert_i(1'b1), .in1_use_i(`CIO_IN_TRIGGER),
        .in2_use_i(`CIO_IN_EXPOSURE), .in1_deb_us_i(deb1), .in2_deb_us_i(8'h01),
        .out1_func_i(func1), .out2_func_i(func2), .strobe_i(req[3]), .event_i(req[2]),
        .out1_level_i(req[1]), .out2_level_i(req[0]), .over_temp_i(st[8]),
        .init_fail_i(st[7]), .not_init_i(st[6]), .link_down_i(st[5]), .wait_ip_i(st[4]),
        .acq_free_i(st[3]), .acq_trig_i(st[2]), .app_conn_i(st[1]), .ip_ok_i(st[0]),
        .link_up_i(net[2]), .link_1000_i(net[1]), .net_act_i(net[0]), .trig_o(trig),
        .expose_o(expo), .out1_o(o1), .out2_o(o2), .status_rgb_o(rgb), .link_led_o(lnk),
        .act_led_o(act)
    );
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic note(input logic [1:0] o);
        q.push_back({et, ex, o, le});
        -> ev;
    endtask
    task automatic cmp(input logic [12:0] e);
        logic [12:0] g;
        g = {ntrig, expo, o2, o1, rgb, lnk, act};
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("unexpected at %0t: outputs %h, wanted %h", $time, g, e);
        end
    endtask
    task automatic final_report();
        $display("checks %0d, mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    always @(ev) cmp(q.pop_front());
    always @(posedge clk) if (trig === 1'b1) ntrig <= ntrig + 4'h1;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 70000) begin
            failures++;
            final_report();
        end
    end
    initial begin
        logic [31:0] r;
        repeat (10) @(negedge clk);
        nrst = 1'b1;
        repeat (100) @(negedge clk);
        ex = 1'b1;
        for (int i = 0; i < 10; i++) begin
            r = rnd();
            st = (i < 9) ? ((9'h100 >> i) | (r[8:0] & ((9'h100 >> i) - 9'h001))) : 9'h000;
            net = r[11:9];
            le = {rgb_t[i], net[2] ? (net[1] ? 2'h2 : 2'h1) : 2'h0, 1'b0};
            @(negedge clk);
            note(2'h0);
        end
        $display("led priority test done");
        src2.drive(1'b1, 100);
        ex = 1'b0;
        note(2'h0);
        src2.drive(1'b0, 100);
        ex = 1'b1;
        note(2'h0);
        for (int k = 0; k < 2; k++) begin
            d = (k == 0) ? 2 : 255;
            deb1 = d[7:0];
            src1.drive(1'b1, 40 * d - 20);
            src1.drive(1'b0, 40 * d + 60);
            note(2'h0);
            src1.drive(1'b1, 40 * d + 60);
            et = et + 4'h1;
            note(2'h0);
            src1.drive(1'b0, 40 * d + 60);
            note(2'h0);
        end
        $display("input conditioning test done");
        for (int f = 0; f < 4; f++) begin
            func1 = f[1:0];
            func2 = 2'h3 - f[1:0];
            req = 4'hF;
            @(negedge clk);
            req = 4'h0;
            note({func2 != 2'h0, func1 != 2'h0});
            repeat (3990) @(negedge clk);
            note({func2 != 2'h0, func1 != 2'h0});
            repeat (20) @(negedge clk);
            note(2'h0);
        end
        $display("output function test done");
        // let the compare process take the last note before the run ends
        @(posedge clk);
        final_report();
    end
endmodule
`default_nettype wire
